/* File: logic/fcx_pkg.sv */
/*
 * Package for the feature control and exception vector block: register
 * offsets, feature bit positions, reset values, vectors and carrier types.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package fcx_pkg;

  localparam logic [7:0]  FEAT_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  TASK_PRIO_LO_OFS  = 8'h04;
  localparam logic [7:0]  TASK_PRIO_HI_OFS  = 8'h08;
  localparam logic [7:0]  INT_CFG_OFS       = 8'h0C;
  localparam logic [7:0]  EXC_STAT_OFS      = 8'h10;
  localparam logic [7:0]  LINT_VEC_OFS      = 8'h14;

  localparam int PVI_BIT    = 1;
  localparam int TSD_BIT    = 2;
  localparam int DBGX_BIT   = 3;
  localparam int LPG_BIT    = 4;
  localparam int PAX_BIT    = 5;
  localparam int MCHK_BIT   = 6;
  localparam int GPG_BIT    = 7;
  localparam int PCR_BIT    = 8;
  localparam int XSS_BIT    = 9;
  localparam int VFPX_BIT   = 10;
  localparam int VIRT_BIT   = 13;
  localparam int PTE_GLOBAL_BIT = 8;

  localparam logic [31:0] FEAT_WMASK      = 32'h0000_27FE;
  localparam logic [31:0] FEAT_CTRL_RST   = 32'h0000_0000;
  localparam logic [3:0]  TASK_PRIO_RST   = 4'h0;
  localparam logic [3:0]  TASK_PRIO_ALL   = 4'hF;
  localparam logic [31:0] INT_CFG_RST     = 32'h0000_0000;
  localparam logic [15:0] LINT_VEC_RST    = 16'h0000;
  localparam int          LIC_EN_BIT      = 0;
  localparam int          LONG_MODE_BIT   = 1;
  localparam int          PAGING_BIT      = 2;

  localparam logic [7:0] VEC_DIVIDE   = 8'h00;
  localparam logic [7:0] VEC_NMI      = 8'h02;
  localparam logic [7:0] VEC_BREAK    = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_BOUND    = 8'h05;
  localparam logic [7:0] VEC_INVOP    = 8'h06;
  localparam logic [7:0] VEC_DEVNA    = 8'h07;
  localparam logic [7:0] VEC_DOUBLE   = 8'h08;
  localparam logic [7:0] VEC_MCHK     = 8'h12;
  localparam logic [7:0] VEC_VECFP    = 8'h13;
  localparam logic [31:0] ERR_ZERO    = 32'h0000_0000;

  typedef enum logic [3:0] {
    EV_NONE     = 4'b0000,
    EV_DIVIDE   = 4'b0001,
    EV_BREAK    = 4'b0010,
    EV_OVERFLOW = 4'b0011,
    EV_BOUND    = 4'b0100,
    EV_INVOP    = 4'b0101,
    EV_DEVNA    = 4'b0110,
    EV_DOUBLE   = 4'b0111,
    EV_MCHK     = 4'b1000,
    EV_VECFP    = 4'b1001
  } fcx_event_t;

  typedef enum logic [2:0] {
    IC_NONE     = 3'b000,
    IC_TIMESTAMP= 3'b001,
    IC_PERFCNT  = 3'b010,
    IC_DEBUG45  = 3'b011,
    IC_VECTOR   = 3'b100,
    IC_VEC_EXEMPT = 3'b101,
    IC_VIRT     = 3'b110
  } fcx_instr_t;

  typedef struct packed {
    logic       valid;
    fcx_instr_t cls;
    logic [1:0] cpl;
  } fcx_instr_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  vector;
    logic        has_err;
    logic [31:0] err_code;
  } fcx_exc_t;

  typedef struct packed {
    logic prot_virtual_int_enable;
    logic timestamp_disable;
    logic dbgx;
    logic large_page;
    logic phys_addr_extension;
    logic mchk;
    logic gpage;
    logic perf;
    logic xsave;
    logic vfpx;
    logic virt;
  } fcx_feat_t;

endpackage : fcx_pkg

/* File: logic/fcx_top.sv */
/*
 * Feature control register, task priority register, local interrupt pin
 * routing and fixed low exception vectors, with an APB register slave.
 * Assumes one core clock, synchronous inputs and an interrupt controller
 * that drives the vector bus from the rise of the maskable request pin.
 */
// Notes on behaviour
// - Bit 1 enables protected-mode virtual interrupt flag.
// - Bit 2 limits timestamp read to level 0.
// - Bit 3 makes debug regs 4/5 fault.
// - Bit 4 allows large pages, else 4K.
// - Bit 5 allows wide physical addresses.
// - Long mode requires physical extension bit set.
// - Machine check raised only when bit 6 set.
// - Bit 7 keeps global TLB entries while paging is on.
// - Bit 8 allows counter read everywhere.
// - Bit 9 enables vector instructions and state.
// - Without bit 9 vector instructions fault, exempt ones.
// - Bit 10 clear turns vector FP into invalid-op.
// - Virtualization allowed only while bit 13 set.
// - Task priority 0 allows all classes above 0, 15 blocks all.
// - Enabled controller maps local pins via table.
// - Disabled controller: pin0 maskable, pin1 non-maskable.
// - Maskable request takes vector from system bus.
// - Non-maskable input delivered on vector 2.
// - Vectors 0,3,4,5 for basic faults/traps.
// - Vectors 6 and 7, no error code.
// - Double fault vector 8, zero error code.
module fcx_top
  import fcx_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  input  wire fcx_pkg::fcx_instr_req_t instr_in,
  input  wire fcx_pkg::fcx_event_t   event_in,
  input  wire logic                  vec_fp_unmasked_in,
  input  wire logic                  pte_global_in,
  input  wire logic [1:0]            local_int_pins_in,
  input  wire logic [7:0]            sys_bus_vector_in,
  input  wire logic [3:0]            int_prio_in,
  output fcx_pkg::fcx_exc_t          exc_out,
  output logic                       instr_allow_out,
  output logic                       tlb_keep_out,
  output fcx_pkg::fcx_feat_t         feat_out,
  output logic                       maskable_int_request_out,
  output logic                       int_ack_out
);
  import fcx_pkg::*;

  logic [31:0] feat_q;
  logic [63:0] prio_q;
  logic [31:0] int_cfg_q;
  logic [15:0] lint_vec_q;
  logic [7:0]  last_vec_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        long_mode_ok;
  logic [31:0] feat_wr;
  logic        lic_en;
  logic        prio_pass;
  logic [1:0]  pin_prev_q;
  logic [1:0]  pin_rise;

  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & ~penable_in & ~pwrite_in;
  assign addr_ok = (paddr_in == FEAT_CTRL_OFS) ||
                   (paddr_in == TASK_PRIO_LO_OFS) ||
                   (paddr_in == TASK_PRIO_HI_OFS) ||
                   (paddr_in == INT_CFG_OFS) ||
                   (paddr_in == EXC_STAT_OFS) ||
                   (paddr_in == LINT_VEC_OFS);
  assign feat_wr = pwdata_in & FEAT_WMASK;
  // Long mode stays off unless the physical extension bit is set
  assign long_mode_ok = feat_q[PAX_BIT];
  assign lic_en = int_cfg_q[LIC_EN_BIT];

  // Registers written here take effect from the next cycle, so no
  // instruction already checked sees the new value
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      feat_q <= FEAT_CTRL_RST;
    end else if (wr_en && paddr_in == FEAT_CTRL_OFS) begin
      feat_q <= feat_wr;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      prio_q <= {60'h0, TASK_PRIO_RST};
    end else if (wr_en && paddr_in == TASK_PRIO_LO_OFS) begin
      prio_q[31:0] <= {28'h0, pwdata_in[3:0]};
    end else if (wr_en && paddr_in == TASK_PRIO_HI_OFS) begin
      prio_q[63:32] <= 32'h0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      int_cfg_q  <= INT_CFG_RST;
      lint_vec_q <= LINT_VEC_RST;
    end else if (wr_en && paddr_in == INT_CFG_OFS) begin
      int_cfg_q <= {29'h0, pwdata_in[PAGING_BIT],
                    pwdata_in[LONG_MODE_BIT] & long_mode_ok,
                    pwdata_in[LIC_EN_BIT]};
    end else if (wr_en && paddr_in == LINT_VEC_OFS) begin
      lint_vec_q <= pwdata_in[15:0];
    end else if (!long_mode_ok) begin
      int_cfg_q[LONG_MODE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      prdata_out  <= 32'h0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~addr_ok;
      if (rd_en) begin
        case (paddr_in)
          FEAT_CTRL_OFS:    prdata_out <= feat_q;
          TASK_PRIO_LO_OFS: prdata_out <= prio_q[31:0];
          TASK_PRIO_HI_OFS: prdata_out <= prio_q[63:32];
          INT_CFG_OFS:      prdata_out <= int_cfg_q;
          EXC_STAT_OFS:     prdata_out <= {24'h0, last_vec_q};
          LINT_VEC_OFS:     prdata_out <= {16'h0, lint_vec_q};
          default:          prdata_out <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      feat_out <= '0;
    end else begin
      feat_out.prot_virtual_int_enable        <= feat_q[PVI_BIT];
      feat_out.timestamp_disable        <= feat_q[TSD_BIT];
      feat_out.dbgx       <= feat_q[DBGX_BIT];
      feat_out.large_page <= feat_q[LPG_BIT];
      feat_out.phys_addr_extension        <= feat_q[PAX_BIT];
      feat_out.mchk       <= feat_q[MCHK_BIT];
      feat_out.gpage      <= feat_q[GPG_BIT];
      feat_out.perf       <= feat_q[PCR_BIT];
      feat_out.xsave      <= feat_q[XSS_BIT];
      feat_out.vfpx       <= feat_q[VFPX_BIT];
      feat_out.virt       <= feat_q[VIRT_BIT];
    end
  end

  // Global entries survive flushes only with the feature on; software is
  // expected to have paging on first, hardware does not reorder it
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      tlb_keep_out <= 1'b0;
    end else begin
      tlb_keep_out <= feat_q[GPG_BIT] & pte_global_in &
                      int_cfg_q[PAGING_BIT];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      instr_allow_out <= 1'b0;
    end else if (instr_in.valid) begin
      case (instr_in.cls)
        IC_TIMESTAMP:
          instr_allow_out <= ~feat_q[TSD_BIT] || instr_in.cpl == 2'h0;
        IC_PERFCNT:
          instr_allow_out <= feat_q[PCR_BIT] || instr_in.cpl == 2'h0;
        IC_DEBUG45:
          instr_allow_out <= ~feat_q[DBGX_BIT];
        IC_VECTOR:
          instr_allow_out <= feat_q[XSS_BIT];
        IC_VEC_EXEMPT:
          instr_allow_out <= 1'b1;
        IC_VIRT:
          instr_allow_out <= feat_q[VIRT_BIT];
        default:
          instr_allow_out <= 1'b1;
      endcase
    end else begin
      instr_allow_out <= 1'b0;
    end
  end

  // Priority 0 passes every class above 0, 15 blocks every class
  assign prio_pass = (prio_q[3:0] != TASK_PRIO_ALL) &&
                     (int_prio_in > prio_q[3:0]);
  assign pin_rise = local_int_pins_in & ~pin_prev_q;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pin_prev_q <= 2'b00;
    end else begin
      pin_prev_q <= local_int_pins_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      maskable_int_request_out <= 1'b0;
      int_ack_out              <= 1'b0;
    end else begin
      maskable_int_request_out <= ~lic_en & local_int_pins_in[0];
      int_ack_out <= ~lic_en & pin_rise[0] & ~pin_rise[1] &
                     prio_pass;
    end
  end

  // Source priority: double fault, non-maskable, machine check,
  // faults from the core, then local pins
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      exc_out    <= '0;
      last_vec_q <= 8'h0;
    end else begin
      exc_out <= '0;
      if (event_in == EV_DOUBLE) begin
        exc_out <= '{1'b1, VEC_DOUBLE, 1'b1, ERR_ZERO};
      end else if (!lic_en && pin_rise[1]) begin
        exc_out <= '{1'b1, VEC_NMI, 1'b0, ERR_ZERO};
      end else if (event_in == EV_MCHK) begin
        if (feat_q[MCHK_BIT]) begin
          exc_out <= '{1'b1, VEC_MCHK, 1'b0, ERR_ZERO};
        end
      end else if (event_in == EV_VECFP && vec_fp_unmasked_in) begin
        exc_out <= '{1'b1, feat_q[VFPX_BIT] ? VEC_VECFP : VEC_INVOP,
                     1'b0, ERR_ZERO};
      end else if (event_in != EV_NONE && event_in != EV_VECFP) begin
        case (event_in)
          EV_DIVIDE:   exc_out <= '{1'b1, VEC_DIVIDE, 1'b0, ERR_ZERO};
          EV_BREAK:    exc_out <= '{1'b1, VEC_BREAK, 1'b0, ERR_ZERO};
          EV_OVERFLOW: exc_out <= '{1'b1, VEC_OVERFLOW, 1'b0, ERR_ZERO};
          EV_BOUND:    exc_out <= '{1'b1, VEC_BOUND, 1'b0, ERR_ZERO};
          EV_INVOP:    exc_out <= '{1'b1, VEC_INVOP, 1'b0, ERR_ZERO};
          EV_DEVNA:    exc_out <= '{1'b1, VEC_DEVNA, 1'b0, ERR_ZERO};
          default:     exc_out <= '0;
        endcase
      end else if (lic_en && pin_rise != 2'b00 && prio_pass) begin
        exc_out <= '{1'b1, pin_rise[1] ? lint_vec_q[15:8] :
                     lint_vec_q[7:0], 1'b0, ERR_ZERO};
      end else if (!lic_en && pin_rise[0] && prio_pass) begin
        exc_out <= '{1'b1, sys_bus_vector_in, 1'b0, ERR_ZERO};
      end
      if (exc_out.valid) begin
        last_vec_q <= exc_out.vector;
      end
    end
  end

endmodule : fcx_top

/* File: sim/fcx_pic_model.sv */
/* External interrupt controller model: raises pin 0, drops it on
   acknowledge, supplies the vector while the request stands. */
module fcx_pic_model (
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic       raise_in,
  input  wire logic [7:0] vec_in,
  input  wire logic       ack_in,
  input  wire logic       req_in,
  output logic            pin_out,
  output logic [7:0]      vector_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       done_q;
  logic [7:0] last_q;
  // Vector stands from the pin's rise, since the core may take it at
  // once; a released bus shows the inverse, never a stale vector
  assign vector_out = (pin_out | req_in) ? vec_in : ~last_q;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      last_q <= 8'h00;
    end else if (pin_out | req_in) begin
      last_q <= vec_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || !raise_in) begin
      pin_out <= 1'h0;
      done_q  <= 1'h0;
    end else begin
      done_q  <= done_q | ack_in;
      pin_out <= !(done_q | ack_in);
    end
  end
endmodule : fcx_pic_model

/* File: sim/fcx_props.sv */
/* Port checker for fcx_top, bound to every instance.
   Assumes one clock and a synchronous active-low reset. */
module fcx_props
  import fcx_pkg::*;
(
  input wire logic                   mclk_in,
  input wire logic                   nrst_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic                   pready_out,
  input wire fcx_pkg::fcx_instr_req_t instr_in,
  input wire fcx_pkg::fcx_event_t    event_in,
  input wire logic [1:0]             local_int_pins_in,
  input wire fcx_pkg::fcx_exc_t      exc_out,
  input wire logic                   instr_allow_out,
  input wire fcx_pkg::fcx_feat_t     feat_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pin1_q;
  logic [1:0] pin2_q;
  logic       quiet;
  // Two stages so a late edge detector cannot outrank an event
  always_ff @(posedge mclk_in) begin
    pin1_q <= nrst_in ? local_int_pins_in : 2'h0;
    pin2_q <= nrst_in ? pin1_q : 2'h0;
  end
  assign quiet = (local_int_pins_in | pin1_q | pin2_q) == 2'h0;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  a_pready_zero: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready late");
  a_pready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  a_allow_idle: assert property (!instr_in.valid |=> !instr_allow_out)
    else $error("allow without request");
  a_tsd_gate: assert property (instr_in.valid && instr_in.cpl != 2'h0 &&
    instr_in.cls == IC_TIMESTAMP |=> instr_allow_out == !feat_out.timestamp_disable)
    else $error("timestamp gate wrong");
  a_perf_gate: assert property (instr_in.valid && instr_in.cpl != 2'h0 &&
    instr_in.cls == IC_PERFCNT |=> instr_allow_out == feat_out.perf)
    else $error("counter gate wrong");
  a_virt_gate: assert property (instr_in.valid && instr_in.cls == IC_VIRT
    |=> instr_allow_out == feat_out.virt)
    else $error("virtualization gate wrong");
  a_low_vectors: assert property (quiet &&
    event_in inside {[EV_DIVIDE:EV_DEVNA]} |=> exc_out.valid && !exc_out.has_err
    && exc_out.vector == (($past(event_in) == EV_DIVIDE) ? 8'h00 :
    8'($past(event_in)) + 8'h01))
    else $error("low vector wrong");
  a_double_fault: assert property (event_in == EV_DOUBLE |=>
    exc_out.valid && exc_out.vector == VEC_DOUBLE && exc_out.has_err &&
    exc_out.err_code == ERR_ZERO)
    else $error("double fault wrong");
  a_mchk_off: assert property (event_in == EV_MCHK && quiet
    |=> exc_out.valid == feat_out.mchk)
    else $error("machine check while off");
  cover property (exc_out.valid && exc_out.vector == VEC_NMI);
  cover property (exc_out.valid && exc_out.has_err);
  cover property (instr_allow_out);
endmodule : fcx_props

bind fcx_top fcx_props i_fcx_props (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .instr_in(instr_in),
  .event_in(event_in), .local_int_pins_in(local_int_pins_in),
  .exc_out(exc_out), .instr_allow_out(instr_allow_out), .feat_out(feat_out)
);

/* File: sim/tb_top.sv */
/* Self-checking bench for fcx_top over APB.
   Assumes zero-wait-state APB and one-cycle answers. */
module tb_top;
  import fcx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, psel, penable, pwrite, pte_g, vfp_um, raise, pin0, pin1;
  logic pready, pslverr, allow, keep, mreq, ack, err;
  logic [7:0]  paddr, vec, sb_vec;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  prio;
  fcx_instr_req_t instr;
  fcx_event_t     ev;
  fcx_exc_t       exc;
  fcx_feat_t      feat;
  int fails, cmp_count;
  int          gb[7] = '{2, 2, 8, 3, 9, 9, 13};
  fcx_instr_t  gc[7] = '{IC_TIMESTAMP, IC_TIMESTAMP, IC_PERFCNT, IC_DEBUG45,
                         IC_VECTOR, IC_VEC_EXEMPT, IC_VIRT};
  logic [1:0]  gl[7] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h3, 2'h3, 2'h0};
  logic [1:0]  ga[7] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h2, 2'h3, 2'h2};
  fcx_top i_fcx_top (.mclk_in(mclk), .nrst_in(nrst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .instr_in(instr), .event_in(ev),
    .vec_fp_unmasked_in(vfp_um), .pte_global_in(pte_g),
    .local_int_pins_in({pin1, pin0}), .sys_bus_vector_in(sb_vec),
    .int_prio_in(prio), .exc_out(exc), .instr_allow_out(allow),
    .tlb_keep_out(keep), .feat_out(feat),
    .maskable_int_request_out(mreq), .int_ack_out(ack));
  fcx_pic_model i_fcx_pic_model (.mclk_in(mclk), .nrst_in(nrst),
    .raise_in(raise), .vec_in(vec), .ack_in(ack), .req_in(mreq),
    .pin_out(pin0), .vector_out(sb_vec));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      fails++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task instr_chk(fcx_instr_t c, logic [1:0] l, logic e);
    @(posedge mclk);
    instr <= {1'h1, c, l};
    @(posedge mclk);
    instr <= '0;
    #1 chk("allow", 32'(e), 32'(allow));
  endtask : instr_chk
  task ev_chk(fcx_event_t e, logic v, logic [7:0] vc, logic he);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= EV_NONE;
    #1 chk("exc valid", 32'(v), 32'(exc.valid));
    if (v) chk("exc vector/err", 32'({vc, he}),
               32'({exc.vector, exc.has_err}));
    if (he) chk("err code", ERR_ZERO, exc.err_code);
  endtask : ev_chk
  task pin_chk(logic [7:0] vc, logic v, logic ak, logic mq);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (exc.valid !== 1'h1 && n < 10);
    chk("pin exc valid", 32'(v), 32'(exc.valid));
    if (v) chk("pin vector", 32'(vc), 32'(exc.vector));
    chk("int ack", 32'(ak), 32'(ack));
    chk("maskable req", 32'(mq), 32'(mreq));
    @(posedge mclk);
    {raise, pin1} <= 2'h0;
  endtask : pin_chk
  task tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200us;
    fails++;
    tally_and_finish();
  end
  initial begin
    {nrst, psel, penable, pwrite, pte_g, vfp_um, raise, pin1} = '0;
    {paddr, pwdata, prio, instr, ev, vec} = {8'h0, 32'h0, 4'h5, 6'h0,
      EV_NONE, 8'h41};
    repeat (10) @(posedge mclk);
    nrst <= 1'h1;
    apb(1'h0, TASK_PRIO_HI_OFS, 32'h0);
    chk("prio hi", 32'h0, rd);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'h1, FEAT_CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'h0, FEAT_CTRL_OFS, 32'h0);
    chk("feat mask", FEAT_WMASK, rd);
    chk("feat out", 32'h7FF, 32'(feat));
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      apb(1'h1, FEAT_CTRL_OFS, 32'h0);
      instr_chk(gc[i], gl[i], ga[i][0]);
      apb(1'h1, FEAT_CTRL_OFS, 32'h1 << gb[i]);
      instr_chk(gc[i], gl[i], ga[i][1]);
    end
    $display("test instruction gates done");
    apb(1'h1, FEAT_CTRL_OFS, 32'h0);
    vfp_um <= 1'h1;
    for (int e = 1; e <= 7; e++)
      ev_chk(fcx_event_t'(e), 1'h1, 8'(e == 1 ? 0 : e + 1), e == 7);
    ev_chk(EV_MCHK, 1'h0, 8'h0, 1'h0);
    ev_chk(EV_VECFP, 1'h1, VEC_INVOP, 1'h0);
    apb(1'h1, FEAT_CTRL_OFS, 32'h440);
    ev_chk(EV_MCHK, 1'h1, VEC_MCHK, 1'h0);
    ev_chk(EV_VECFP, 1'h1, VEC_VECFP, 1'h0);
    $display("test exceptions done");
    apb(1'h1, INT_CFG_OFS, 32'h4);
    apb(1'h1, FEAT_CTRL_OFS, 32'h80);
    pte_g <= 1'h1;
    repeat (2) @(posedge mclk);
    #1 chk("tlb keep", 32'h1, 32'(keep));
    apb(1'h1, INT_CFG_OFS, 32'h6);
    apb(1'h0, INT_CFG_OFS, 32'h0);
    chk("long mode refused", 32'h4, rd);
    apb(1'h1, FEAT_CTRL_OFS, 32'h20);
    apb(1'h1, INT_CFG_OFS, 32'h6);
    apb(1'h0, INT_CFG_OFS, 32'h0);
    chk("long mode taken", 32'h6, rd);
    $display("test paging done");
    apb(1'h1, INT_CFG_OFS, 32'h0);
    raise <= 1'h1;
    pin_chk(8'h41, 1'h1, 1'h1, 1'h1);
    @(posedge mclk);
    pin1 <= 1'h1;
    pin_chk(VEC_NMI, 1'h1, 1'h0, 1'h0);
    apb(1'h1, TASK_PRIO_LO_OFS, 32'hF);
    raise <= 1'h1;
    pin_chk(8'h0, 1'h0, 1'h0, 1'h1);
    apb(1'h1, TASK_PRIO_LO_OFS, 32'h0);
    apb(1'h1, LINT_VEC_OFS, 32'h5150);
    apb(1'h1, INT_CFG_OFS, 32'h1);
    raise <= 1'h1;
    pin_chk(8'h50, 1'h1, 1'h0, 1'h0);
    apb(1'h0, EXC_STAT_OFS, 32'h0);
    chk("last vector", 32'h50, rd);
    $display("test pins done");
    tally_and_finish();
  end
endmodule : tb_top
